// ==== rio_map_pkg.sv ====
// Purpose: Shared constants and types for the remote I/O image mapper.
// Assumes: Relay addresses fit in 14 bits; one byte per relay address.
// Notes: Window sizes are counted in bytes.
`default_nettype none
package rio_map_pkg;
   localparam int ADDR_W = 14;
   localparam int DI_BYTES = 8;
   localparam int DO_BYTES = 6;
   localparam int UNIT_DO_BYTES = 3;
   localparam int FIFO_DEPTH = 4;
   localparam int G1_EN_BIT = 4;
   localparam int G2_EN_BIT = 5;
   localparam int ALM_G1_BASIC = 0;
   localparam int ALM_G1_EXT = 1;
   localparam int ALM_G2_BASIC = 2;
   localparam int ALM_G2_EXT = 3;
   localparam logic [13:0] LO_TOP_DEF = 14'h05db;
   localparam logic [13:0] HI_START = 14'h238c;
   localparam logic [14:0] HI_END = 15'h239e;
   localparam logic [7:0] DO_RESET = 8'h00;
   localparam logic [3:0] ALM_UPPER = 4'h0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } relay_wr_type;

   typedef struct packed {
      logic [ADDR_W-1:0] start;
      logic [3:0] size;
   } win_type;

   typedef struct packed {
      win_type di;
      win_type dout;
   } group_cfg_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DI = 3'b001,
      S_DO = 3'b011,
      S_ALM = 3'b010,
      S_DONE = 3'b110
   } scan_state_type;
endpackage
`default_nettype wire

// ==== rio_image_mapper.sv ====
// Purpose: Copies remote DI bytes into the relay image and remote DO bytes out of it.
// Assumes: Relay memory write port takes one word per valid/ready; reads return next cycle.
// Notes: Windows that run out of the allowed relay range are skipped whole.
`timescale 1ns/10ps
`default_nettype none

module rio_wr_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wp_ff, rp_ff;
   logic [PW:0] cnt_ff;
   logic push, pop;

   // Full and empty come from the occupancy count only
   assign in_ready_o = (cnt_ff != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rp_ff];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Storage has no reset, pointers do
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wp_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wp_ff <= (wp_ff == PW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
         if (pop) rp_ff <= (rp_ff == PW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
         cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

//Contract
//[RULE1] Input window size is 0..4 bytes basic only, 0..8 with extended unit.
//[RULE2] Output window size is 0..3 bytes basic only, 0..6 with extended unit.
//[RULE3] Only bytes from input start address for input size are input data.
//[RULE4] Output data is taken only from the configured output window bytes.
//[RULE5] Group one maps only when use bit 4 set; group two when bit 5.
//[RULE6] A window whose end leaves the allowed relay range transfers nothing.
//[RULE7] Start and alarm addresses lie in 0..1499 or 0..2999, plus 9100..9117.
//[RULE8] Alarm bits 0..3 flag group1 basic, group1 ext, group2 basic, group2 ext.
//[RULE9] A faulted driver holds its whole output byte off until the fault clears.
//[RULE10] Driver faults raise no system alarm; block only reports them and runs on.
//[RULE11] Transfers start only after ladder controller and servo both started.
//[RULE12] Data-valid flag shows 1 when module data is valid; ladder checks it.
//[RULE13] Configurer keeps all windows non-overlapping with each other and other units.
//[RULE14] Each byte from the window start moves atomically; multi-byte not guaranteed.
//[RULE15] Configurer never enables an extended unit without its basic unit.
//[RULE16] Slave translation value is 16 for the near group, 48 for the far.
//[RULE17] Alarm status bits 7..4 read as zero.
module rio_image_mapper import rio_map_pkg::*; #(
   parameter logic [13:0] RELAY_LO_TOP = LO_TOP_DEF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Configuration
   input wire logic [15:0] module_use_i,
   input wire group_cfg_type [1:0] group_cfg_i,
   input wire logic [ADDR_W-1:0] alarm_addr_i,
   // Startup status
   input wire logic ladder_started_i,
   input wire logic servo_started_i,
   output logic data_valid_o,
   // Remote module pins
   input wire logic [1:0][DI_BYTES-1:0][7:0] remote_di_i,
   input wire logic [1:0][DO_BYTES-1:0] driver_fault_i,
   output logic [1:0][DO_BYTES-1:0][7:0] remote_do_o,
   // Alarm status
   output logic [7:0] alarm_status_o,
   // Relay memory write port
   output logic mem_wr_valid_o,
   input wire logic mem_wr_ready_i,
   output relay_wr_type mem_wr_o,
   // Relay memory read port
   output logic mem_rd_en_o,
   output logic [ADDR_W-1:0] mem_rd_addr_o,
   input wire logic [7:0] mem_rd_data_i
);
   localparam logic [14:0] LO_END = {1'b0, RELAY_LO_TOP} + 15'h0001;

   scan_state_type state_ff;
   logic grp_ff;
   logic [2:0] byt_ff;
   logic [1:0][DI_BYTES-1:0][7:0] di_s1_ff, di_s2_ff, di_s3_ff, di_ff;
   logic [1:0][DO_BYTES-1:0] flt_s1_ff, flt_s2_ff, flt_s3_ff, flt_ff, flt_d_ff;
   logic [1:0][DO_BYTES-1:0][7:0] img_ff, do_ff;
   logic [3:0] unit_alm;
   logic [3:0] alm_ff;
   logic valid_ff, rd_pend_ff, rd_grp_ff;
   logic [2:0] rd_byt_ff;
   logic [1:0] grp_en;
   win_type di_w, do_w;
   logic di_act, do_act, alm_ok, push, push_ready, last_byte;
   relay_wr_type push_word;

   // Window end must stay inside the low range or the high block
   function automatic logic win_ok(input logic [ADDR_W-1:0] st, input logic [3:0] sz);
      logic [14:0] e;
      e = {1'b0, st} + {11'h000, sz};
      win_ok = (e <= LO_END) || ((st >= HI_START) && (e <= HI_END));
   endfunction

   assign grp_en = {module_use_i[G2_EN_BIT], module_use_i[G1_EN_BIT]}; // [RULE5]
   assign di_w = group_cfg_i[grp_ff].di;
   assign do_w = group_cfg_i[grp_ff].dout;
   // Byte is moved only if group enabled, window legal and byte inside size
   assign di_act = grp_en[grp_ff] && win_ok(di_w.start, di_w.size) && ({1'b0, byt_ff} < di_w.size); // [RULE3] [RULE6]
   assign do_act = grp_en[grp_ff] && win_ok(do_w.start, do_w.size) && ({1'b0, byt_ff} < do_w.size); // [RULE4] [RULE6]
   assign alm_ok = win_ok(alarm_addr_i, 4'h1);
   assign last_byte = (state_ff == S_DI) ? (byt_ff == 3'(DI_BYTES-1)) : (byt_ff == 3'(DO_BYTES-1));

   // Writes of DI bytes and the alarm byte go through the FIFO
   always_comb begin
      push = 1'b0;
      push_word = '0;
      if (state_ff == S_DI && di_act) begin
         push = 1'b1;
         push_word.addr = di_w.start + ADDR_W'(byt_ff);
         push_word.data = di_ff[grp_ff][byt_ff]; // [RULE14]
      end else if (state_ff == S_ALM && alm_ok) begin
         push = 1'b1;
         push_word.addr = alarm_addr_i;
         push_word.data = alarm_status_o;
      end
   end

   rio_wr_fifo #(.WIDTH($bits(relay_wr_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(push),
      .in_ready_o(push_ready),
      .in_data_i(push_word),
      .out_valid_o(mem_wr_valid_o),
      .out_ready_i(mem_wr_ready_i),
      .out_data_o(mem_wr_o)
   );

   // Pin inputs: three stages, a byte or bit changes once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         di_s1_ff <= '0;
         di_s2_ff <= '0;
         di_s3_ff <= '0;
         di_ff <= '0;
      end else begin
         di_s1_ff <= remote_di_i;
         di_s2_ff <= di_s1_ff;
         di_s3_ff <= di_s2_ff;
         for (int g = 0; g < 2; g++) begin
            for (int b = 0; b < DI_BYTES; b++) begin
               if (di_s2_ff[g][b] == di_s3_ff[g][b]) di_ff[g][b] <= di_s3_ff[g][b]; // [RULE14]
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         flt_s1_ff <= '0;
         flt_s2_ff <= '0;
         flt_s3_ff <= '0;
         flt_ff <= '0;
         flt_d_ff <= '0;
      end else begin
         flt_s1_ff <= driver_fault_i;
         flt_s2_ff <= flt_s1_ff;
         flt_s3_ff <= flt_s2_ff;
         flt_ff <= (flt_s2_ff & flt_s3_ff) | (flt_ff & (flt_s2_ff | flt_s3_ff));
         flt_d_ff <= flt_ff;
      end
   end

   // Scan sequencer; stalls only while a DI or alarm word waits on a full FIFO
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_ff <= S_IDLE;
         grp_ff <= 1'b0;
         byt_ff <= 3'h0;
      end else begin
         case (state_ff)
            S_IDLE: begin
               if (ladder_started_i && servo_started_i) state_ff <= S_DI; // [RULE11]
            end
            S_DI, S_DO: begin
               if (!push || push_ready) begin
                  byt_ff <= last_byte ? 3'h0 : byt_ff + 3'h1;
                  if (last_byte) begin
                     grp_ff <= ~grp_ff;
                     if (grp_ff) state_ff <= (state_ff == S_DI) ? S_DO : S_ALM;
                  end
               end
            end
            S_ALM: begin
               if (!push || push_ready) state_ff <= S_DONE;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // DO bytes are read one per cycle; out-of-window bytes are cleared
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rd_pend_ff <= 1'b0;
         rd_grp_ff <= 1'b0;
         rd_byt_ff <= 3'h0;
         img_ff <= '0;
      end else begin
         rd_pend_ff <= mem_rd_en_o;
         rd_grp_ff <= grp_ff;
         rd_byt_ff <= byt_ff;
         if (rd_pend_ff) img_ff[rd_grp_ff][rd_byt_ff] <= mem_rd_data_i; // [RULE14]
         if (state_ff == S_DO && !do_act) img_ff[grp_ff][byt_ff] <= DO_RESET; // [RULE4] [RULE5]
      end
   end

   assign mem_rd_en_o = (state_ff == S_DO) && do_act;
   assign mem_rd_addr_o = do_w.start + ADDR_W'(byt_ff);

   // A faulted driver forces its byte off; protection never stops the scan
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         do_ff <= '0;
      end else begin
         for (int g = 0; g < 2; g++) begin
            for (int b = 0; b < DO_BYTES; b++) begin
               do_ff[g][b] <= flt_ff[g][b] ? DO_RESET : img_ff[g][b]; // [RULE9] [RULE10]
            end
         end
      end
   end

   // Per-unit alarm: basic owns bytes 0..2, extended bytes 3..5
   always_comb begin
      unit_alm[ALM_G1_BASIC] = |flt_ff[0][UNIT_DO_BYTES-1:0];
      unit_alm[ALM_G1_EXT] = |flt_ff[0][DO_BYTES-1:UNIT_DO_BYTES];
      unit_alm[ALM_G2_BASIC] = |flt_ff[1][UNIT_DO_BYTES-1:0];
      unit_alm[ALM_G2_EXT] = |flt_ff[1][DO_BYTES-1:UNIT_DO_BYTES];
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) alm_ff <= '0;
      else alm_ff <= unit_alm; // [RULE8] [RULE10]
   end

   // Valid after the first complete scan; dropped when either party stops
   always_ff @(posedge clk_i) begin
      if (!rstn_i) valid_ff <= 1'b0;
      else if (!(ladder_started_i && servo_started_i)) valid_ff <= 1'b0; // [RULE11]
      else if (state_ff == S_DONE) valid_ff <= 1'b1; // [RULE12]
   end

   assign data_valid_o = valid_ff;
   assign remote_do_o = do_ff;
   assign alarm_status_o = {ALM_UPPER, alm_ff}; // [RULE17]

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   fault_byte_off_a: assert property (flt_d_ff[0][0] |-> do_ff[0][0] == DO_RESET) // [RULE9]
      else $error("faulted output byte not held off");
   fault_byte_off2_a: assert property (flt_d_ff[1][5] |-> do_ff[1][5] == DO_RESET) // [RULE9]
      else $error("faulted extended output byte not held off");
   alarm_bit_map_a: assert property (##1 alarm_status_o[3:0] == $past(unit_alm)) // [RULE8]
      else $error("alarm status does not follow unit faults");
   alarm_upper_zero_a: assert property (alarm_status_o[7:4] == 4'h0) // [RULE17]
      else $error("alarm status upper bits not zero");
   valid_after_start_a: assert property ($rose(data_valid_o) |-> $past(ladder_started_i && servo_started_i)) // [RULE11]
      else $error("data valid without both parties started");
   valid_drop_a: assert property (!(ladder_started_i && servo_started_i) |=> !data_valid_o) // [RULE12]
      else $error("data valid kept after stop");
   di_in_window_a: assert property (push && state_ff == S_DI |-> (push_word.addr - di_w.start) < ADDR_W'(di_w.size)) // [RULE3]
      else $error("input byte written outside window");
   group_gate_a: assert property ((push && state_ff == S_DI) || mem_rd_en_o |-> grp_en[grp_ff]) // [RULE5]
      else $error("disabled group transferred data");
   range_skip_a: assert property (mem_rd_en_o |-> win_ok(do_w.start, do_w.size)) // [RULE6]
      else $error("out of range output window read");
   do_in_window_a: assert property (mem_rd_en_o |-> {1'b0, byt_ff} < do_w.size) // [RULE4]
      else $error("output byte read outside window");
   scan_runs_a: assert property (state_ff == S_ALM |-> ##[1:8] state_ff == S_DONE || !mem_wr_ready_i) // [RULE10]
      else $error("scan stalled without back-pressure");
endmodule
`default_nettype wire

// ==== rio_remote_units.sv ====
// Purpose: Behavioural remote I/O units that feed DI bytes and driver faults to the mapper.
// Assumes: Unit pins are plain levels; the mapper synchronises them itself.
// Notes: Each DI byte carries its group and byte number, so a misplaced byte is caught.
`timescale 1ns/10ps
`default_nettype none
module rio_remote_units import rio_map_pkg::*; (
   // Clock
   input wire logic clk_i,
   // Bench control
   input wire logic [7:0] di_base_i,
   input wire logic [1:0][DO_BYTES-1:0] fault_req_i,
   // Unit pins
   output logic [1:0][DI_BYTES-1:0][7:0] remote_di_o,
   output logic [1:0][DO_BYTES-1:0] driver_fault_o
);
   // Pins change on the unit's own update, never while the bench is sampling
   always_ff @(posedge clk_i) begin
      for (int g = 0; g < 2; g++) begin
         for (int b = 0; b < DI_BYTES; b++) begin
            remote_di_o[g][b] <= di_base_i ^ 8'(g * 16 + b);
         end
      end
      driver_fault_o <= fault_req_i; // A driver flags only while it is overloaded
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the remote I/O image mapper.
// Assumes: Relay memory is modelled here; it stalls writes to exercise the FIFO.
// Notes: Settle waits span a few scans, as no per-scan completion signal exists.
`timescale 1ns/10ps
`default_nettype none
module tb import rio_map_pkg::*; ;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] module_use = 16'h0030;
   group_cfg_type [1:0] cfg = '0;
   logic [ADDR_W-1:0] alarm_addr = 14'h00c8;
   logic ladder_on = 1'b0;
   logic servo_on = 1'b0;
   logic data_valid;
   logic [1:0][DI_BYTES-1:0][7:0] di;
   logic [1:0][DO_BYTES-1:0] fault;
   logic [1:0][DO_BYTES-1:0] fault_req = '0;
   logic [1:0][DO_BYTES-1:0][7:0] rdo;
   logic [7:0] alarm_status;
   logic wr_valid;
   logic wr_ready = 1'b0;
   relay_wr_type wr;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] di_base = 8'ha5;
   logic stall = 1'b0;
   logic [7:0] mem [0:16383];
   int stall_cnt = 0;
   int n_fail = 0;
   int compares = 0;

   // 50 ns clock
   always #25 clk_i = ~clk_i;

   rio_remote_units u_units (.clk_i(clk_i), .di_base_i(di_base), .fault_req_i(fault_req),
      .remote_di_o(di), .driver_fault_o(fault));

   rio_image_mapper u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .module_use_i(module_use),
      .group_cfg_i(cfg), .alarm_addr_i(alarm_addr), .ladder_started_i(ladder_on),
      .servo_started_i(servo_on), .data_valid_o(data_valid), .remote_di_i(di),
      .driver_fault_i(fault), .remote_do_o(rdo), .alarm_status_o(alarm_status),
      .mem_wr_valid_o(wr_valid), .mem_wr_ready_i(wr_ready), .mem_wr_o(wr),
      .mem_rd_en_o(rd_en), .mem_rd_addr_o(rd_addr), .mem_rd_data_i(rd_data));

   // Relay memory: takes a word when valid meets ready, answers reads one cycle later
   always @(posedge clk_i) begin
      if (wr_valid && wr_ready) mem[wr.addr] = wr.data;
      if (rd_en) rd_data <= #1 mem[rd_addr];
      stall_cnt = stall_cnt + 1;
      wr_ready <= #1 !stall && (stall_cnt % 3 != 0); // Regular stalls back up the FIFO
   end

   function automatic logic [7:0] di_exp(input logic [7:0] base, input int g, input int b);
      return base ^ 8'(g * 16 + b);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   // A DI window holds the unit bytes and the byte just past it is untouched
   task automatic chk_di(input int start, input int size, input logic [7:0] base, input int g);
      for (int b = 0; b < size; b++) chk(mem[start + b], di_exp(base, g, b));
      chk(mem[start + size], 8'h5a);
   endtask

   task automatic set_win(input int g, input int dis, input int dsz, input int dos, input int osz);
      cfg[g].di.start = 14'(dis); // Sizes kept within unit limits
      cfg[g].di.size = 4'(dsz);
      cfg[g].dout.start = 14'(dos); // Windows never overlap
      cfg[g].dout.size = 4'(osz);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Watchdog well beyond the little over a thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = 8'h5a;
      for (int b = 0; b < 6; b++) mem[100 + b] = 8'h80 + 8'(b);
      for (int b = 0; b < 3; b++) mem[9110 + b] = 8'h90 + 8'(b);
      for (int b = 0; b < 3; b++) mem[9106 + b] = 8'hc0 + 8'(b);
      set_win(0, 10, 8, 100, 6); // Both units fitted in group one, basic unit only in group two
      set_win(1, 9100, 4, 9110, 3);
      repeat (12) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      // Startup: one party started only, then the FIFO held full by a stalled memory
      ladder_on = 1'b1;
      stall = 1'b1;
      tick(100);
      chk({7'h00, data_valid}, 8'h00);
      chk(rdo[0][0], 8'h00);
      servo_on = 1'b1;
      tick(80);
      chk({7'h00, data_valid}, 8'h00);
      chk({7'h00, wr_valid}, 8'h01);
      stall = 1'b0;
      for (int i = 0; i < 2000 && data_valid !== 1'b1; i++) tick(1);
      chk({7'h00, data_valid}, 8'h01);
      tick(150);
      chk_di(10, 8, 8'ha5, 0);
      chk_di(9100, 4, 8'ha5, 1);
      chk(mem[9], 8'h5a);
      for (int b = 0; b < 6; b++) chk(rdo[0][b], 8'h80 + 8'(b));
      for (int b = 0; b < 6; b++) chk(rdo[1][b], (b < 3) ? 8'h90 + 8'(b) : 8'h00);
      chk(mem[200], 8'h00);
      $display("test startup and mapping done");
      // Group two switched off: only group one follows new pins and image
      module_use = 16'h0010;
      di_base = 8'h3c;
      mem[100] = 8'he7;
      tick(150);
      chk_di(10, 8, 8'h3c, 0);
      chk_di(9100, 4, 8'ha5, 1);
      chk(rdo[0][0], 8'he7);
      chk(rdo[1][0], 8'h00);
      $display("test group enable done");
      // Range edges: one DI window ends one past the high top, another exactly at the low top
      // The skipped window sits in the other block so no two windows share a relay byte
      module_use = 16'h0030;
      set_win(0, 9111, 8, 100, 6);
      set_win(1, 1496, 4, 9106, 3);
      tick(150);
      for (int b = 2; b < 6; b++) chk(mem[9111 + b], 8'h5a);
      chk_di(1496, 4, 8'h3c, 1);
      for (int b = 0; b < 3; b++) chk(rdo[1][b], 8'hc0 + 8'(b));
      $display("test range limits done");
      // Driver faults: alarm bits 1 and 2, then bits 0 and 3, the faulted byte held off, run goes on
      fault_req[0][4] = 1'b1;
      fault_req[1][0] = 1'b1;
      tick(150);
      chk(alarm_status, 8'h06);
      chk(mem[200], 8'h06);
      chk(rdo[0][4], 8'h00);
      chk(rdo[0][3], 8'h83);
      chk(rdo[1][0], 8'h00);
      chk({7'h00, data_valid}, 8'h01);
      fault_req = '0;
      fault_req[0][0] = 1'b1;
      fault_req[1][5] = 1'b1;
      tick(150);
      chk(alarm_status, 8'h09);
      chk(mem[200], 8'h09);
      chk(rdo[0][4], 8'h84);
      fault_req = '0;
      tick(150);
      chk(alarm_status, 8'h00);
      chk(rdo[0][0], 8'he7);
      $display("test driver alarms done");
      // Servo stops: module data is no longer valid
      servo_on = 1'b0;
      tick(4);
      chk({7'h00, data_valid}, 8'h00);
      $display("test shutdown done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
